// ===== core/uart1_pkg.sv
// Package of constants for the serial port 1 control and rate generator
package uart1_pkg;
	localparam logic [7:0] ADDR_PORT_CONTROL = 8'h98;
	localparam logic [7:0] ADDR_DATA_BUFFER = 8'h99;
	localparam logic [7:0] ADDR_RATE_RELOAD = 8'h9a;
	localparam logic [7:0] ADDR_RATE_COUNTER = 8'h9b;
	localparam logic [7:0] ADDR_PORT_CONFIG = 8'h9c;
	localparam logic [7:0] RST_PORT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PORT_CONFIG = 8'h20;
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_BUFFER = 8'h00;
	// Control field positions
	localparam int CTL_MODE0 = 7;
	localparam int CTL_MODE1 = 6;
	localparam int CTL_ADDR = 5;
	localparam int CTL_REN = 4;
	localparam int CTL_TB8 = 3;
	localparam int CTL_RB8 = 2;
	localparam int CTL_TI = 1;
	localparam int CTL_RI = 0;
	// Config field positions
	localparam int CFG_MODE3 = 7;
	localparam int CFG_RUN = 4;
	localparam int CFG_DOUBLE = 3;
	localparam int CFG_SRC = 2;
	localparam int CFG_CKOE = 1;
	localparam int CFG_TME = 0;
	localparam logic [3:0] PRESCALE_LAST = 4'hb;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	typedef enum logic [2:0] {
		MODE_SHIFT = 3'b000,
		MODE_UART8 = 3'b001,
		MODE_UART9_FIXED = 3'b010,
		MODE_UART9_VAR = 3'b011,
		MODE_SPI = 3'b100
	} port_mode_e;
endpackage : uart1_pkg

// ===== core/uart1_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module uart1_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready_o = (cnt_q < (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];

	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data_i;
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : uart1_fifo

// ===== core/uart1_ctrl_baud_generator.sv
// Serial port 1 control registers, transmit FIFO, receive buffer and baud rate generator
// Operation
// - Eight-bit up-counter on sysclk/12 or sysclk
// - Overflow reloads counter from reload register
// - Overflow toggles clock output and peripheral clock
// - Port0 timer1 overflow replaced under alternate select
// - Port0 rate follows reload, doubling bit unused
// - Both ports share overflow in modes 1/3
// - Three mode bits select port mode
// - Modes 2/3 addressing needs ninth bit, match
// - Mode 1 addressing needs stop bit, match
// - Reception only while receive enable set
// - Ninth transmit bit from control in modes 2/3
// - Received ninth bit field per mode
// - Transmit flag set by engine, software clears
// - Receive flag set by engine, software clears
// - Data buffer writes fill transmit FIFO, reads return receive buffer
// - Reload write copies counter when timer mode off
// - Source select zero divides by twelve
// - Run bit gates counter, enable gates output
`timescale 1ns/1ps
module uart1_ctrl_baud_generator
	import uart1_pkg::*;
#(
	parameter int FIFO_WIDTH = 8,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Special function register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Port 0 selection bits
	input wire logic port0_alt_rate_sel_i,
	input wire logic port0_tx_timer2_sel_i,
	input wire logic port0_rx_timer2_sel_i,
	input wire logic port0_is_var_mode_i,
	input wire logic timer1_overflow_i,
	output logic port0_rate_tick_o,
	// Generator outputs
	output logic rate_overflow_flag_o,
	output logic gen_clock_out_o,
	output logic periph_clock_o,
	// Serial engine side
	input wire logic eng_tx_done_i,
	input wire logic eng_rx_done_i,
	input wire logic [7:0] eng_rx_data_i,
	input wire logic eng_rx_ninth_i,
	input wire logic eng_rx_stop_i,
	input wire logic eng_addr_match_i,
	output logic [2:0] port_mode_o,
	output logic rx_enable_o,
	output logic tx_ninth_bit_o,
	output logic port1_rate_tick_o,
	// Transmit data stream to the engine
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] tx_data_o,
	output logic tx_load_ready_o
);
	logic [7:0] ctl_q, ctl_d, cfg_q, cfg_d, rld_q, rld_d, cnt_q, cnt_d, buf_q, buf_d, rdata_q, rdata_d;
	logic [3:0] pre_q, pre_d;
	logic ovf_q, ovf_d, cko_q, cko_d, pclk_q, pclk_d, p0_q, p0_d, p1_q, p1_d;
	logic tick, ovf, set_ri, wr_ctl, fifo_in_ready;
	logic [2:0] mode;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	uart1_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(sfr_wr_i && hit(sfr_addr_i, ADDR_DATA_BUFFER)),
		.in_ready_o(fifo_in_ready),
		.in_data_i(sfr_wdata_i),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i),
		.out_data_o(tx_data_o)
	);

	always_comb begin
		mode = {cfg_q[CFG_MODE3], ctl_q[CTL_MODE0], ctl_q[CTL_MODE1]};
		wr_ctl = sfr_wr_i && hit(sfr_addr_i, ADDR_PORT_CONTROL);
		pre_d = pre_q;
		tick = 1'b0;
		if (cfg_q[CFG_RUN]) begin
			if (cfg_q[CFG_SRC]) begin
				tick = 1'b1;
			end else begin
				tick = (pre_q == PRESCALE_LAST);
				pre_d = tick ? 4'h0 : pre_q + 4'h1;
			end
		end
		ovf = tick && (cnt_q == COUNT_MAX);
		cnt_d = cnt_q;
		if (ovf) begin
			cnt_d = rld_q;
		end else if (tick) begin
			cnt_d = cnt_q + 8'h01;
		end
		rld_d = rld_q;
		if (sfr_wr_i && hit(sfr_addr_i, ADDR_RATE_RELOAD)) begin
			rld_d = sfr_wdata_i;
			if (!cfg_q[CFG_TME]) begin
				cnt_d = sfr_wdata_i;
			end
		end
		if (sfr_wr_i && hit(sfr_addr_i, ADDR_RATE_COUNTER)) begin
			cnt_d = sfr_wdata_i;
		end
		ovf_d = ovf;
		cko_d = cfg_q[CFG_CKOE] ? (cko_q ^ ovf) : 1'b0;
		pclk_d = pclk_q ^ ovf;
		// Port 0 source selection and shared tick
		p0_d = (port0_is_var_mode_i && !port0_tx_timer2_sel_i && !port0_rx_timer2_sel_i && port0_alt_rate_sel_i)
			? ovf : timer1_overflow_i;
		p1_d = ovf && ((mode == MODE_UART8) || (mode == MODE_UART9_VAR));
		cfg_d = cfg_q;
		if (sfr_wr_i && hit(sfr_addr_i, ADDR_PORT_CONFIG)) begin
			cfg_d = sfr_wdata_i;
		end
		buf_d = buf_q;
		if (eng_rx_done_i && ctl_q[CTL_REN]) begin
			buf_d = eng_rx_data_i;
		end
		// Receive flag qualification
		set_ri = 1'b0;
		if (eng_rx_done_i && ctl_q[CTL_REN] && mode != MODE_SPI) begin
			if (!ctl_q[CTL_ADDR] || mode == MODE_SHIFT) begin
				set_ri = 1'b1;
			end else if (mode == MODE_UART8) begin
				set_ri = eng_rx_stop_i && eng_addr_match_i;
			end else begin
				set_ri = eng_rx_ninth_i && eng_addr_match_i;
			end
		end
		ctl_d = wr_ctl ? sfr_wdata_i : ctl_q;
		if (eng_rx_done_i && ctl_q[CTL_REN] && mode != MODE_SHIFT && mode != MODE_SPI) begin
			if (mode == MODE_UART8) begin
				if (!ctl_q[CTL_ADDR]) begin
					ctl_d[CTL_RB8] = eng_rx_stop_i;
				end
			end else begin
				ctl_d[CTL_RB8] = eng_rx_ninth_i;
			end
		end
		if (eng_tx_done_i) begin
			ctl_d[CTL_TI] = 1'b1;
		end
		if (set_ri) begin
			ctl_d[CTL_RI] = 1'b1;
		end
		rdata_d = 8'h00;
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				ADDR_PORT_CONTROL: rdata_d = ctl_q;
				ADDR_DATA_BUFFER: rdata_d = buf_q;
				ADDR_RATE_RELOAD: rdata_d = rld_q;
				ADDR_RATE_COUNTER: rdata_d = cnt_q;
				ADDR_PORT_CONFIG: rdata_d = cfg_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl_q <= RST_PORT_CONTROL;
			cfg_q <= RST_PORT_CONFIG;
			rld_q <= RST_RATE;
			cnt_q <= RST_RATE;
			buf_q <= RST_BUFFER;
			rdata_q <= 8'h00;
			pre_q <= 4'h0;
			ovf_q <= 1'b0;
			cko_q <= 1'b0;
			pclk_q <= 1'b0;
			p0_q <= 1'b0;
			p1_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			cfg_q <= cfg_d;
			rld_q <= rld_d;
			cnt_q <= cnt_d;
			buf_q <= buf_d;
			rdata_q <= rdata_d;
			pre_q <= pre_d;
			ovf_q <= ovf_d;
			cko_q <= cko_d;
			pclk_q <= pclk_d;
			p0_q <= p0_d;
			p1_q <= p1_d;
		end
	end

	logic rdy_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= fifo_in_ready;
		end
	end

	assign sfr_rdata_o = rdata_q;
	assign port0_rate_tick_o = p0_q;
	assign rate_overflow_flag_o = ovf_q;
	assign gen_clock_out_o = cko_q;
	assign periph_clock_o = pclk_q;
	assign port_mode_o = {cfg_q[CFG_MODE3], ctl_q[CTL_MODE0], ctl_q[CTL_MODE1]};
	assign rx_enable_o = ctl_q[CTL_REN];
	assign tx_ninth_bit_o = ctl_q[CTL_TB8];
	assign port1_rate_tick_o = p1_q;
	assign tx_load_ready_o = rdy_q;
endmodule : uart1_ctrl_baud_generator

// ===== sim/uart1_ctrl_monitor.sv
// Port checker for the serial port 1 control block
`timescale 1ns/1ps
module uart1_ctrl_monitor
	import uart1_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic rate_overflow_flag_o,
	input wire logic gen_clock_out_o,
	input wire logic periph_clock_o,
	input wire logic [2:0] port_mode_o,
	input wire logic rx_enable_o,
	input wire logic tx_ninth_bit_o,
	input wire logic port1_rate_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_ctl_hold: assert property (
		!sfr_wr_i |=> $stable({port_mode_o, rx_enable_o, tx_ninth_bit_o})) else $error("control moved");
	chk_ctl_write: assert property (
		sfr_wr_i && sfr_addr_i == ADDR_PORT_CONTROL |=>
		{port_mode_o[1:0], rx_enable_o, tx_ninth_bit_o} == {$past(sfr_wdata_i[7:6]), $past(sfr_wdata_i[4:3])})
		else $error("control write lost");
	chk_periph_toggle: assert property (
		$changed(periph_clock_o) == rate_overflow_flag_o) else $error("peripheral clock off overflow");
	chk_clkout_rise: assert property (
		$rose(gen_clock_out_o) |-> rate_overflow_flag_o) else $error("clock out rose early");
	chk_tick_flag: assert property (
		port1_rate_tick_o |-> rate_overflow_flag_o) else $error("port tick without overflow");
	chk_tick_shift: assert property (
		$stable(port_mode_o) && port_mode_o == MODE_SHIFT |-> !port1_rate_tick_o) else $error("tick in mode 0");
	chk_read_idle: assert property (
		!sfr_rd_i |=> sfr_rdata_o == 8'h00) else $error("read data without read");
	chk_read_ctl: assert property (
		sfr_rd_i && sfr_addr_i == ADDR_PORT_CONTROL |=>
		{sfr_rdata_o[7:6], sfr_rdata_o[4:3]} == $past({port_mode_o[1:0], rx_enable_o, tx_ninth_bit_o}))
		else $error("control read mismatch");
endmodule : uart1_ctrl_monitor
bind uart1_ctrl_baud_generator uart1_ctrl_monitor i_uart1_ctrl_monitor (.clk_i, .rst_b_i, .sfr_addr_i,
	.sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .rate_overflow_flag_o, .gen_clock_out_o,
	.periph_clock_o, .port_mode_o, .rx_enable_o, .tx_ninth_bit_o, .port1_rate_tick_o);

// ===== sim/uart1_engine_model.sv
// Serial engine stand-in that drains the transmit stream
`timescale 1ns/1ps
module uart1_engine_model (
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	output logic tx_done_o
);
	logic [7:0] got[$];
	initial begin
		tx_ready_o = 1'b0;
		tx_done_o = 1'b0;
	end
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
		tx_done_o <= tx_valid_i && tx_ready_o;
		tx_ready_o <= !stall_i;
	end
endmodule : uart1_engine_model

// ===== sim/tb_top.sv
// Self-checking testbench of the serial port 1 control block
`timescale 1ns/1ps
module tb_top
	import uart1_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] tx_data;
	logic wr = 1'b0, rd_s = 1'b0, alt = 1'b0, rx_done = 1'b0, ninth = 1'b0, match = 1'b0, stall = 1'b1;
	logic tx_ready, tx_done, tx_valid, load_ready, flag, p0tick;
	int n_fail = 0;
	int compares = 0;
	always #5 clk_i = ~clk_i;
	uart1_ctrl_baud_generator i_uart1_ctrl_baud_generator (.clk_i, .rst_b_i, .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .port0_alt_rate_sel_i(alt),
		.port0_tx_timer2_sel_i(1'b0), .port0_rx_timer2_sel_i(1'b0), .port0_is_var_mode_i(alt),
		.timer1_overflow_i(1'b0), .port0_rate_tick_o(p0tick), .rate_overflow_flag_o(flag), .gen_clock_out_o(),
		.periph_clock_o(), .eng_tx_done_i(tx_done), .eng_rx_done_i(rx_done), .eng_rx_data_i(8'ha5),
		.eng_rx_ninth_i(ninth), .eng_rx_stop_i(1'b1), .eng_addr_match_i(match), .port_mode_o(), .rx_enable_o(),
		.tx_ninth_bit_o(), .port1_rate_tick_o(), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.tx_data_o(tx_data), .tx_load_ready_o(load_ready));
	uart1_engine_model i_uart1_engine_model (.clk_i, .stall_i(stall), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready), .tx_done_o(tx_done));
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic stop_test;
		$display("Compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		@(posedge clk_i);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_i);
		rd_s <= 1'b0;
		#1;
		cmp(rdata, e);
		@(posedge clk_i);
	endtask : rd_reg
	task automatic period(input int e);
		int c;
		repeat (2) begin
			c = 0;
			do begin
				@(posedge clk_i);
				#1;
				c++;
			end while (flag !== 1'b1 && c < 400);
		end
		cmp(8'(c), 8'(e));
		cmp({7'h00, p0tick}, 8'h01);
		if (c >= 400) stop_test();
		@(posedge clk_i);
	endtask : period
	task automatic t_regs;
		rd_reg(ADDR_PORT_CONFIG, RST_PORT_CONFIG);
		rd_reg(8'h00, 8'h00);
		wr_reg(ADDR_RATE_RELOAD, 8'h33);
		repeat (30) @(posedge clk_i);
		rd_reg(ADDR_RATE_COUNTER, 8'h33);
		wr_reg(ADDR_RATE_COUNTER, 8'h11);
		rd_reg(ADDR_RATE_RELOAD, 8'h33);
		rd_reg(ADDR_RATE_COUNTER, 8'h11);
		$display("regs done");
	endtask : t_regs
	task automatic t_gen;
		alt <= 1'b1;
		wr_reg(ADDR_PORT_CONTROL, 8'h40);
		wr_reg(ADDR_RATE_RELOAD, 8'hfc);
		wr_reg(ADDR_PORT_CONFIG, 8'h16);
		period(4);
		wr_reg(ADDR_PORT_CONFIG, 8'h02);
		wr_reg(ADDR_RATE_RELOAD, 8'hf0);
		wr_reg(ADDR_PORT_CONFIG, 8'h12);
		period(192);
		wr_reg(ADDR_PORT_CONFIG, 8'h00);
		alt <= 1'b0;
		$display("generator done");
	endtask : t_gen
	task automatic t_fifo;
		for (int i = 0; i < 9; i++) wr_reg(ADDR_DATA_BUFFER, 8'(8'h30 + i));
		cmp({7'h00, load_ready}, 8'h00);
		stall <= 1'b0;
		for (int i = 0; i < 40 && i_uart1_engine_model.got.size() < 8; i++) @(posedge clk_i);
		repeat (4) @(posedge clk_i);
		cmp(8'(i_uart1_engine_model.got.size()), 8'h08);
		foreach (i_uart1_engine_model.got[i]) cmp(i_uart1_engine_model.got[i], 8'(8'h30 + i));
		stall <= 1'b1;
		rd_reg(ADDR_PORT_CONTROL, 8'h42);
		$display("buffer done");
	endtask : t_fifo
	task automatic t_rx;
		logic [7:0] ctl[4] = '{8'h50, 8'hf0, 8'hf0, 8'he0};
		logic [7:0] expv[4] = '{8'h55, 8'hf4, 8'hf5, 8'he0};
		for (int i = 0; i < 4; i++) begin
			wr_reg(ADDR_PORT_CONTROL, ctl[i]);
			ninth <= i > 0;
			match <= i > 1;
			rx_done <= 1'b1;
			@(posedge clk_i);
			rx_done <= 1'b0;
			@(posedge clk_i);
			rd_reg(ADDR_PORT_CONTROL, expv[i]);
		end
		rd_reg(ADDR_DATA_BUFFER, 8'ha5);
		$display("receive done");
	endtask : t_rx
	initial begin
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_gen();
		t_fifo();
		t_rx();
		stop_test();
	end
endmodule : tb_top
